// ==== src/deewc_pkg.sv ====
// constants, types and register map of the data eeprom write controller
package deewc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses on the axi4-lite bus)
  localparam logic [15:0] DEEWC_CTRL_OFS = 16'h0030;  // nvm_control_status
  localparam logic [15:0] DEEWC_PWR_OFS = 16'h0034;   // power state, read only
  localparam logic [15:0] DEEWC_OPT_OFS = 16'h0038;   // readout protection option
  localparam logic [15:0] DEEWC_EE_BASE = 16'h1000;   // eeprom window, one byte per word
  localparam int DEEWC_EE_SEL_LSB = 9;                // window spans 512 bytes

  // control register fields
  localparam int DEEWC_PGM_POS = 0;                   // program_go_bit
  localparam int DEEWC_CAP_POS = 1;                   // write_capture_mode
  localparam logic [7:0] DEEWC_CTRL_RST = 8'h00;
  localparam logic [7:0] DEEWC_OPT_RST = 8'h00;

  // array geometry
  localparam int DEEWC_ROWS = 4;
  localparam int DEEWC_ROW_BYTES = 32;
  localparam int DEEWC_BYTES = DEEWC_ROWS * DEEWC_ROW_BYTES;
  localparam logic [7:0] DEEWC_ERASED = 8'hFF;

  // timing in core_clk cycles
  localparam int DEEWC_PROG_CYCLES_DEF = 200;
  localparam logic [15:0] DEEWC_ERASE_CYCLES = 16'h0008;

  // axi responses
  localparam logic [1:0] DEEWC_OKAY = 2'b00;
  localparam logic [1:0] DEEWC_SLVERR = 2'b10;
  localparam logic [1:0] DEEWC_DECERR = 2'b11;

  // controller states
  typedef enum logic [2:0] {
    DEEWC_IDLE = 3'b000,
    DEEWC_PROG = 3'b001,
    DEEWC_WAIT = 3'b010,
    DEEWC_HALT = 3'b011,
    DEEWC_ERASE = 3'b100
  } deewc_state_e;

  // control/status bits travelling together
  typedef struct packed {
    logic cap;  // write_capture_mode
    logic program_go_short;  // program_go_bit
  } deewc_ctrl_s;

  // cpu power-mode requests
  typedef struct packed {
    logic halt;  // halt instruction
    logic wait_; // sleep_wait_instruction or active halt
  } deewc_pwr_s;

endpackage

// ==== src/deewc_top.sv ====
// data eeprom write controller with axi4-lite slave and behavioural cell array
`timescale 1ns/1ps
module deewc_top
  import deewc_pkg::*;
#(
  parameter int PROG_CYCLES = DEEWC_PROG_CYCLES_DEF  // programming cycle length in clocks
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire deewc_pwr_s cpu_pwr_req,
  output logic nvm_busy,
  output logic nvm_wait_ack,
  output logic pm_erase_req
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES);  // counter load value
  localparam int PROG_LEN = PROG_CYCLES + 1;             // bound for checks

  // address falls in the eeprom window
  function automatic logic is_ee(input logic [15:0] a);
    return a[15:DEEWC_EE_SEL_LSB] == DEEWC_EE_BASE[15:DEEWC_EE_SEL_LSB];
  endfunction

  // byte index inside the eeprom
  function automatic logic [6:0] ee_idx(input logic [15:0] a);
    return a[8:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] mem [DEEWC_BYTES];          // nonvolatile cells
  logic [7:0] row_latch [DEEWC_ROW_BYTES]; // write latches, no read path
  logic [31:0] lat_valid;                 // latch written since last clear
  logic [1:0] last_row;                   // row of the latest captured write
  deewc_ctrl_s ctrl;                      // capture and go bits
  logic prot;                             // readout protection option
  deewc_state_e state;                    // controller state
  logic [15:0] cnt;                       // cycle timer

  // axi slave state
  logic aw_hold;          // address accepted, waiting to execute
  logic w_hold;           // data accepted, waiting to execute
  logic [15:0] awaddr_q;  // held write address
  logic [31:0] wdata_q;   // held write data
  logic wlane0_q;         // low byte lane enabled

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  wire wr_fire = aw_hold & w_hold & ~s_axi_bvalid;  // write executes this cycle
  wire wr_ctrl = wr_fire & wlane0_q & (awaddr_q == DEEWC_CTRL_OFS);
  wire wr_opt = wr_fire & wlane0_q & (awaddr_q == DEEWC_OPT_OFS);
  wire wr_ee_any = wr_fire & is_ee(awaddr_q);
  wire wr_ee = wr_ee_any & wlane0_q;
  wire wr_mapped = wr_ee_any | (awaddr_q == DEEWC_CTRL_OFS) | (awaddr_q == DEEWC_OPT_OFS)
                   | (awaddr_q == DEEWC_PWR_OFS);
  wire [6:0] wr_i = ee_idx(awaddr_q);
  wire [4:0] wr_col = wr_i[4:0];
  wire [7:0] wr_byte = wdata_q[7:0];
  wire [7:0] and_val = row_latch[wr_col] & wr_byte;  // over-program value
  // captured eeprom write, blocked outside capture mode and under protection
  wire lat_wr = wr_ee & ctrl.cap & ~ctrl.program_go_short & ~prot;
  wire lat_and_fire = lat_wr & lat_valid[wr_col];

  // control register write intentions
  wire sw_set_pgm = wr_ctrl & wr_byte[DEEWC_PGM_POS];
  wire sw_clr_pgm = wr_ctrl & ~wr_byte[DEEWC_PGM_POS];
  wire sw_set_cap = wr_ctrl & wr_byte[DEEWC_CAP_POS];
  wire sw_clr_cap = wr_ctrl & ~wr_byte[DEEWC_CAP_POS];

  // state events
  wire halt_req = cpu_pwr_req.halt;
  wire wait_req = cpu_pwr_req.wait_;
  wire in_prog = (state == DEEWC_PROG);
  wire prog_done = in_prog & (cnt == 16'h0001) & ~halt_req & ~sw_clr_pgm;
  wire prog_abort = in_prog & sw_clr_pgm & ~halt_req;
  wire prog_start = (state == DEEWC_IDLE) & sw_set_pgm & ~prot & ~halt_req & ~wait_req;
  wire erase_start = (state == DEEWC_IDLE) & wr_opt & prot & ~wr_byte[0] & ~halt_req;
  wire erase_done = (state == DEEWC_ERASE) & (cnt == 16'h0001) & ~halt_req;

  ////////////////////////////////////////////////////////////////////////////
  // next state and control bits
  deewc_state_e next_state;
  deewc_ctrl_s next_ctrl;
  logic [15:0] next_cnt;
  logic next_prot;

  always_comb begin
    next_state = state;
    next_cnt = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
    next_ctrl = ctrl;
    next_prot = prot;
    if (halt_req) begin
      // halt drops everything at once, data of a running cycle is lost
      next_state = DEEWC_HALT;
      next_ctrl = '0;
      next_cnt = 16'h0000;
    end else begin
      case (state)
        DEEWC_IDLE: begin
          if (wait_req) begin
            next_state = DEEWC_WAIT;
          end else if (prog_start) begin
            next_state = DEEWC_PROG;
            next_ctrl.program_go_short = 1'b1;
            next_cnt = PROG_LOAD;
          end else if (erase_start) begin
            next_state = DEEWC_ERASE;
            next_cnt = DEEWC_ERASE_CYCLES;
          end
          // capture set by software, clear only while go is clear
          if (sw_set_cap & ~prot) begin
            next_ctrl.cap = 1'b1;
          end else if (sw_clr_cap) begin
            next_ctrl.cap = 1'b0;
          end
          if (wr_opt & wr_byte[0]) begin
            next_prot = 1'b1;
          end
        end
        DEEWC_PROG: begin
          if (prog_done) begin
            // both bits fall on the same edge
            next_ctrl = '0;
            next_state = wait_req ? DEEWC_WAIT : DEEWC_IDLE;
          end else if (prog_abort) begin
            next_ctrl.program_go_short = 1'b0;
            next_state = DEEWC_IDLE;
            next_cnt = 16'h0000;
          end
        end
        DEEWC_WAIT: begin
          if (!wait_req) begin
            next_state = DEEWC_IDLE;
          end
        end
        DEEWC_HALT: begin
          next_state = DEEWC_IDLE;
        end
        DEEWC_ERASE: begin
          if (erase_done) begin
            next_state = DEEWC_IDLE;
            next_prot = 1'b0;
            next_ctrl = '0;
          end
        end
        default: begin
          next_state = DEEWC_IDLE;
        end
      endcase
    end
  end

  // latches clear whenever capture falls, which includes cycle end
  wire lat_clr = ctrl.cap & ~next_ctrl.cap;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= DEEWC_IDLE;
      ctrl <= deewc_ctrl_s'(DEEWC_CTRL_RST[1:0]);
      prot <= DEEWC_OPT_RST[0];
      cnt <= 16'h0000;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      prot <= next_prot;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row latches
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lat_valid <= 32'h0000_0000;
      last_row <= 2'b00;
    end else if (lat_clr) begin
      lat_valid <= 32'h0000_0000;
    end else if (lat_wr) begin
      lat_valid[wr_col] <= 1'b1;
      last_row <= wr_i[6:5];
    end
  end

  // latch data, and of old and new when already written
  always_ff @(posedge core_clk) begin
    if (lat_wr & ~lat_clr) begin
      row_latch[wr_col] <= lat_valid[wr_col] ? and_val : wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell array: row burn at cycle end, full erase on protection removal
  always_ff @(posedge core_clk) begin
    if (erase_done) begin
      for (int i = 0; i < DEEWC_BYTES; i++) begin
        mem[i] <= DEEWC_ERASED;
      end
    end else if (prog_done) begin
      for (int c = 0; c < DEEWC_ROW_BYTES; c++) begin
        if (lat_valid[c]) begin
          mem[{last_row, 5'(c)}] <= row_latch[c];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode, latches have no path here
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_is_ee = is_ee(s_axi_araddr);
  wire rd_is_ctrl = (s_axi_araddr == DEEWC_CTRL_OFS);
  wire rd_is_pwr = (s_axi_araddr == DEEWC_PWR_OFS);
  wire rd_is_opt = (s_axi_araddr == DEEWC_OPT_OFS);
  wire rd_ee_ok = rd_is_ee & ~ctrl.cap & ~prot;
  wire [7:0] rd_cell = mem[ee_idx(s_axi_araddr)];
  wire [7:0] rd_ctrl_val = {6'b00_0000, ctrl.cap, ctrl.program_go_short};
  wire [7:0] rd_pwr_val = {5'b0_0000, state};
  wire [31:0] rd_data = rd_ee_ok ? {24'h00_0000, rd_cell} :
                        rd_is_ctrl ? {24'h00_0000, rd_ctrl_val} :
                        rd_is_pwr ? {24'h00_0000, rd_pwr_val} :
                        rd_is_opt ? {31'h0000_0000, prot} : 32'h0000_0000;
  wire [1:0] rd_resp = rd_ee_ok | rd_is_ctrl | rd_is_pwr | rd_is_opt ? DEEWC_OKAY :
                       rd_is_ee ? DEEWC_SLVERR : DEEWC_DECERR;
  wire [1:0] wr_resp = ~wr_mapped ? DEEWC_DECERR : (wr_ee_any & prot) ? DEEWC_SLVERR : DEEWC_OKAY;

  // axi handshake next values
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire next_aw_hold = (aw_hold | aw_take) & ~wr_fire;
  wire next_w_hold = (w_hold | w_take) & ~wr_fire;
  wire next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  ////////////////////////////////////////////////////////////////////////////
  // axi write channels
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DEEWC_OKAY;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      wlane0_q <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= ~next_aw_hold & ~next_bvalid;
      s_axi_wready <= ~next_w_hold & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= wr_resp;
      end
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wlane0_q <= s_axi_wstrb[0];
      end
    end
  end

  // axi read channels
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DEEWC_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // status outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      nvm_busy <= 1'b0;
      nvm_wait_ack <= 1'b0;
      pm_erase_req <= 1'b0;
    end else begin
      nvm_busy <= (next_state == DEEWC_PROG) | (next_state == DEEWC_ERASE);
      nvm_wait_ack <= (next_state == DEEWC_WAIT) | (next_state == DEEWC_HALT);
      pm_erase_req <= erase_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic rd_ctrl_q;  // last accepted read hit the control register
  logic rd_blk_q;   // last accepted read hit the eeprom in capture mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_ctrl_q <= 1'b0;
      rd_blk_q <= 1'b0;
    end else if (ar_take) begin
      rd_ctrl_q <= rd_is_ctrl;
      rd_blk_q <= rd_is_ee & ctrl.cap;
    end
  end

  property p_end_clears;
    @(posedge core_clk) disable iff (!nrst) prog_done |=> !ctrl.program_go_short && !ctrl.cap && lat_valid == 0;
  endproperty
  a_end_clears: assert property (p_end_clears) else $error("cycle end left bits set");

  property p_cycle_len;
    @(posedge core_clk) disable iff (!nrst) $rose(ctrl.program_go_short) |-> ##[1:PROG_LEN] !ctrl.program_go_short;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not ended by timer");

  property p_go_reads;
    @(posedge core_clk) disable iff (!nrst) ctrl.program_go_short == (state == DEEWC_PROG);
  endproperty
  a_go_reads: assert property (p_go_reads) else $error("go bit disagrees with cycle");

  property p_ctrl_zero;
    @(posedge core_clk) disable iff (!nrst) s_axi_rvalid && rd_ctrl_q |-> s_axi_rdata[31:2] == 30'h0000_0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("reserved control bits nonzero");

  property p_cap_read;
    @(posedge core_clk) disable iff (!nrst)
      s_axi_rvalid && rd_blk_q |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == DEEWC_SLVERR;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("eeprom read drove data in capture mode");

  property p_no_capture;
    @(posedge core_clk) disable iff (!nrst) wr_ee && !ctrl.cap |=> $stable(lat_valid);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("latch changed outside capture");

  property p_and_rewrite;
    @(posedge core_clk) disable iff (!nrst) lat_and_fire && !lat_clr |=> row_latch[$past(wr_col)] == $past(and_val);
  endproperty
  a_and_rewrite: assert property (p_and_rewrite) else $error("rewrite did not and");

  property p_fall_clears;
    @(posedge core_clk) disable iff (!nrst) $fell(ctrl.cap) |-> lat_valid == 32'h0000_0000;
  endproperty
  a_fall_clears: assert property (p_fall_clears) else $error("latches survive capture fall");

  property p_wait_idle;
    @(posedge core_clk) disable iff (!nrst) wait_req && !halt_req && state == DEEWC_IDLE |=> state == DEEWC_WAIT;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("idle wait not entered");

  property p_halt_stop;
    @(posedge core_clk) disable iff (!nrst) halt_req |=> state == DEEWC_HALT && !ctrl.program_go_short ##1 !nvm_busy;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop");

  c_prog_done: cover property (@(posedge core_clk) disable iff (!nrst) prog_done);
  c_wait_busy: cover property (@(posedge core_clk) disable iff (!nrst) in_prog && wait_req ##1 in_prog);
  c_erase: cover property (@(posedge core_clk) disable iff (!nrst) erase_done);
  c_and: cover property (@(posedge core_clk) disable iff (!nrst) lat_and_fire);

endmodule

// ==== test/deewc_cpu_model.sv ====
// cpu side bus master model issuing one axi4-lite access per request
`timescale 1ns/1ps
module deewc_cpu_model
  import deewc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdat,
  output logic done,
  output logic [31:0] rdat,
  output logic [1:0] resp,
  output logic [15:0] awaddr = 16'h0000,
  output logic awvalid = 1'b0,
  input wire logic awready,
  output logic [31:0] wdata = 32'h0000_0000,
  output logic [3:0] wstrb = 4'h1,
  output logic wvalid = 1'b0,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready = 1'b0,
  output logic [15:0] araddr = 16'h0000,
  output logic arvalid = 1'b0,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready = 1'b0
);
  logic busy = 1'b0; // one access under way at a time

  ////////////////////////////////////////////////////////////
  // launch on go, release each channel on its own handshake, capture the answer
  always @(posedge core_clk) begin
    done <= 1'b0;
    if (!nrst) begin
      busy <= 1'b0;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b0;
      arvalid <= 1'b0;
      rready <= 1'b0;
    end else if (!busy) begin
      if (go) begin
        // address and data come straight from the caller, held until each handshake
        busy <= 1'b1;
        awaddr <= addr;
        araddr <= addr;
        wdata <= {24'h00_0000, wdat};
        awvalid <= we;
        wvalid <= we;
        bready <= we;
        arvalid <= !we;
        rready <= !we;
      end
    end else begin
      // released payloads are inverted so a stale value never looks valid
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      // answers end the access
      if (bready && bvalid) begin
        bready <= 1'b0;
        resp <= bresp;
        busy <= 1'b0;
        done <= 1'b1;
      end
      if (rready && rvalid) begin
        rready <= 1'b0;
        resp <= rresp;
        rdat <= rdata;
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule

// ==== test/deewc_top_test.sv ====
// self-checking bench for the data eeprom write controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module deewc_top_test
  import deewc_pkg::*;
;
  localparam int PCYC = 32; // shortened programming cycle, long enough for a mid-cycle access
  logic core_clk;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic we = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdat = 8'h00;
  logic done;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [15:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  deewc_pwr_s pwr = 2'b00; // cpu power-mode levels
  logic busy, wack, erq;
  int erase_cnt = 0; // pulses seen on the erase request
  int errors = 0;
  int checks = 0;

  deewc_top #(.PROG_CYCLES(PCYC)) u_dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_pwr_req(pwr), .nvm_busy(busy),
    .nvm_wait_ack(wack), .pm_erase_req(erq));

  deewc_cpu_model u_cpu (.core_clk(core_clk), .nrst(nrst), .go(go), .we(we), .addr(addr), .wdat(wdat),
    .done(done), .rdat(rdat), .resp(resp), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ////////////////////////////////////////////////////////////
  // clock and erase pulse counter
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (erq === 1'b1) erase_cnt++;
  end

  // byte address of eeprom cell i
  function automatic logic [15:0] ea(input int i);
    return DEEWC_EE_BASE + 16'(4 * i);
  endfunction

  // one bus access through the model, bounded wait for its answer
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    we <= w;
    addr <= a;
    wdat <= d;
    @(posedge core_clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("bus answer", 1'b1, done)
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    acc(1'b1, a, d);
    `CHK("write resp", er, resp)
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] er, input logic [7:0] ed);
    acc(1'b0, a, 8'h00);
    `CHK("read resp", er, resp)
    if (er !== DEEWC_DECERR) `CHK("read data", {24'h00_0000, ed}, rdat)
  endtask
  // bounded wait until programming or erasing ends
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("busy", 1'b0, busy)
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_protect();
    int c;
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h00);
    wr(DEEWC_OPT_OFS, 8'h01, DEEWC_OKAY);
    rd(DEEWC_OPT_OFS, DEEWC_OKAY, 8'h01);
    rd(ea(0), DEEWC_SLVERR, 8'h00);
    wr(ea(0), 8'h00, DEEWC_SLVERR);
    c = erase_cnt;
    wr(DEEWC_OPT_OFS, 8'h00, DEEWC_OKAY);
    wait_idle();
    repeat (2) @(posedge core_clk);
    `CHK("erase pulses", c + 1, erase_cnt)
    rd(ea(0), DEEWC_OKAY, DEEWC_ERASED);
    rd(ea(127), DEEWC_OKAY, DEEWC_ERASED);
    $display("test protect done");
  endtask
  task automatic t_reserved();
    wr(DEEWC_CTRL_OFS, 8'hFC, DEEWC_OKAY);
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h00);
    rd(16'h0040, DEEWC_DECERR, 8'h00);
    wr(16'h0044, 8'h00, DEEWC_DECERR);
    $display("test reserved done");
  endtask
  task automatic t_program();
    wr(DEEWC_CTRL_OFS, 8'h02, DEEWC_OKAY);
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h02);
    wr(ea(32), 8'h5A, DEEWC_OKAY);
    wr(ea(63), 8'hF0, DEEWC_OKAY);
    wr(ea(63), 8'h3C, DEEWC_OKAY);
    rd(ea(32), DEEWC_SLVERR, 8'h00);
    wr(DEEWC_CTRL_OFS, 8'h03, DEEWC_OKAY);
    `CHK("busy", 1'b1, busy)
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h03);
    wr(DEEWC_CTRL_OFS, 8'h01, DEEWC_OKAY);
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h03);
    wait_idle();
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h00);
    rd(ea(32), DEEWC_OKAY, 8'h5A);
    rd(ea(63), DEEWC_OKAY, 8'h30);
    rd(ea(33), DEEWC_OKAY, DEEWC_ERASED);
    rd(ea(0), DEEWC_OKAY, DEEWC_ERASED);
    $display("test program done");
  endtask
  task automatic t_ignore();
    wr(ea(40), 8'h00, DEEWC_OKAY);
    rd(ea(40), DEEWC_OKAY, DEEWC_ERASED);
    wr(DEEWC_CTRL_OFS, 8'h02, DEEWC_OKAY);
    wr(ea(40), 8'h00, DEEWC_OKAY);
    wr(DEEWC_CTRL_OFS, 8'h00, DEEWC_OKAY);
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h00);
    wr(DEEWC_CTRL_OFS, 8'h02, DEEWC_OKAY);
    wr(DEEWC_CTRL_OFS, 8'h03, DEEWC_OKAY);
    wait_idle();
    rd(ea(40), DEEWC_OKAY, DEEWC_ERASED);
    $display("test ignore done");
  endtask
  task automatic t_power();
    @(posedge core_clk);
    pwr <= 2'b01;
    repeat (3) @(posedge core_clk);
    `CHK("wait ack idle", 1'b1, wack)
    pwr <= 2'b00;
    repeat (3) @(posedge core_clk);
    `CHK("wait ack off", 1'b0, wack)
    wr(DEEWC_CTRL_OFS, 8'h02, DEEWC_OKAY);
    wr(ea(64), 8'h81, DEEWC_OKAY);
    wr(DEEWC_CTRL_OFS, 8'h03, DEEWC_OKAY);
    pwr <= 2'b01;
    `CHK("busy", 1'b1, busy)
    wait_idle();
    repeat (3) @(posedge core_clk);
    `CHK("wait ack busy", 1'b1, wack)
    rd(DEEWC_PWR_OFS, DEEWC_OKAY, 8'h02);
    pwr <= 2'b00;
    repeat (3) @(posedge core_clk);
    rd(ea(64), DEEWC_OKAY, 8'h81);
    wr(DEEWC_CTRL_OFS, 8'h02, DEEWC_OKAY);
    wr(ea(96), 8'h00, DEEWC_OKAY);
    wr(DEEWC_CTRL_OFS, 8'h03, DEEWC_OKAY);
    pwr <= 2'b10;
    repeat (3) @(posedge core_clk);
    `CHK("halt busy", 1'b0, busy)
    `CHK("halt ack", 1'b1, wack)
    pwr <= 2'b00;
    repeat (3) @(posedge core_clk);
    rd(DEEWC_CTRL_OFS, DEEWC_OKAY, 8'h00);
    rd(ea(96), DEEWC_OKAY, DEEWC_ERASED);
    $display("test power done");
  endtask

  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence: reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_protect();
    t_reserved();
    t_program();
    t_ignore();
    t_power();
    give_verdict();
  end
  // watchdog well past the expected run of about four hundred cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
endmodule
